// ==== rtl/fsmon_pkg.sv ====
// constants and types shared by the fan and sensor monitor files
package fsmon_pkg;
  // sensor population
  localparam int NUM_AN   = 14;  // threshold sensors: 4 temperatures, 10 voltages
  localparam int NUM_FAN  = 6;   // individual fan connectors
  localparam int NUM_PACK = 5;   // fans usable through the fan pack connector
  localparam int NUM_TERM = 4;   // terminator voltage sensors
  localparam int NUM_PEER = 8;   // peer controllers that may report fan faults
  localparam int NUM_AMB  = 4;   // ambient threshold / duty pairs
  localparam int VID_W    = 5;   // voltage_id_bits width
  localparam int AW       = 10;  // register address width
  // sensor slots
  localparam int SEN_AMBIENT = 1;   // front panel ambient temperature
  localparam int SEN_CPU1_T  = 2;   // processor 1 temperature
  localparam int SEN_CPU2_T  = 3;   // processor 2 temperature
  localparam int SEN_VCORE   = 8;   // processor core voltage
  localparam int NUM_TEMP    = 4;   // slots 0..3 are temperatures
  // register offsets (byte addresses)
  localparam logic [AW-1:0] OFF_CTRL     = 10'h000;
  localparam logic [AW-1:0] OFF_STATUS   = 10'h004;
  localparam logic [AW-1:0] OFF_EVENT    = 10'h008;
  localparam logic [AW-1:0] OFF_PEER     = 10'h00C;
  localparam logic [AW-1:0] OFF_DUTY     = 10'h010;
  localparam logic [AW-1:0] OFF_AMB      = 10'h020;
  localparam logic [AW-1:0] OFF_FAN_CRIT = 10'h040;
  localparam logic [AW-1:0] OFF_FAN_STAT = 10'h060;
  localparam logic [AW-1:0] OFF_SEN_THR  = 10'h080;
  localparam logic [AW-1:0] OFF_SEN_STAT = 10'h0C0;
  // control register fields
  localparam int CTRL_TEMP_AUTO = 0;   // temperature threshold auto-configuration
  localparam int CTRL_VRM_ONLY  = 1;   // processors fed by core_voltage_regulator only
  localparam int CTRL_PACK      = 2;   // 1: fan pack connector, 0: individual connectors
  localparam int CTRL_POP_LSB   = 8;   // populated connector mask, 6 bits
  localparam int CTRL_DIG_LSB   = 16;  // digital fan type mask, 6 bits
  // reset values
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
  localparam logic [31:0] SEN_THR_RST  = 32'h0000_FFFF;
  localparam logic [15:0] AMB_RST      = 16'hFFFF;
  localparam logic [7:0]  DUTY_LOW_RST = 8'h40;
  localparam logic [7:0]  FULL_DUTY    = 8'hFF;
  // voltage_id_bits to nominal core voltage reading
  localparam logic [7:0] VID_NOM_BASE = 8'hC0;  // reading for code zero
  localparam logic [7:0] VID_NOM_STEP = 8'h04;  // reading drop per code step
  localparam logic [7:0] VID_TOL      = 8'h08;  // nominal tolerance band
  localparam logic [7:0] VID_ACC      = 8'h04;  // extra room for sense accuracy
  // timing
  localparam int CLK_MHZ      = 200;
  localparam int KICK_TIME_US = 2000;   // fan kick start interval
  localparam int KICK_CYC_DEF = KICK_TIME_US * CLK_MHZ;
  localparam int PWM_DIV_DEF  = 4;      // clock cycles per pwm step
  // one sensor's thresholds, laid out as in its register
  typedef struct packed {
    logic [7:0] lc;   // lower critical
    logic [7:0] lnc;  // lower non-critical
    logic [7:0] unc;  // upper non-critical
    logic [7:0] uc;   // upper critical
  } fsmon_thr_t;
endpackage

// ==== rtl/fsmon_thr_if.sv ====
// link between the monitor and one threshold comparator
`timescale 1ns/1ps
interface fsmon_thr_if import fsmon_pkg::*; ();
  logic [7:0] reading;     // current 8-bit reading
  fsmon_thr_t thr;         // active thresholds
  logic       upper_only;  // lower thresholds not evaluated
  logic [3:0] flags;       // {uc, unc, lnc, lc}
  modport mon (output reading, output thr, output upper_only, input flags);
  modport cmp (input reading, input thr, input upper_only, output flags);
endinterface // fsmon_thr_if

// ==== rtl/fsmon_thr_cmp.sv ====
// threshold comparator for one 8-bit sensor reading
`timescale 1ns/1ps
module fsmon_thr_cmp
  import fsmon_pkg::*;
(
  fsmon_thr_if.cmp t
);
  // upper crossings always evaluated
  assign t.flags[3] = (t.reading >= t.thr.uc);
  assign t.flags[2] = (t.reading >= t.thr.unc);
  // lower crossings suppressed in upper-only mode
  assign t.flags[1] = !t.upper_only && (t.reading <= t.thr.lnc);
  assign t.flags[0] = !t.upper_only && (t.reading <= t.thr.lc);
endmodule // fsmon_thr_cmp

// ==== rtl/fsmon_monitor.sv ====
// sensor threshold monitor and fan speed controller
`timescale 1ns/1ps
module fsmon_monitor
  import fsmon_pkg::*;
#(
  parameter int KICK_CYCLES = KICK_CYC_DEF,  // power-up high speed cycles
  parameter int PWM_DIV     = PWM_DIV_DEF    // clock cycles per pwm step
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_b_i,
  input  wire logic [AW-1:0]         addr_i,
  input  wire logic [31:0]           wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic      [31:0]           rdata_o,
  input  wire logic [NUM_AN*8-1:0]   an_rd_i,
  input  wire logic [NUM_FAN*8-1:0]  tach_rd_i,
  input  wire logic [VID_W-1:0]      vid_a_i,
  input  wire logic [VID_W-1:0]      vid_b_i,
  input  wire logic [NUM_FAN-1:0]    fan_present_i,
  input  wire logic [NUM_FAN-1:0]    fan_dig_fail_i,
  input  wire logic [NUM_TERM-1:0]   term_se_ok_i,
  input  wire logic [NUM_TERM-1:0]   term_lvd_ok_i,
  input  wire logic                  ac_ok_i,
  input  wire logic                  sys_pwr_i,
  input  wire logic                  hard_rst_i,
  output logic                       pwm_o,
  output logic                       fan_high_o,
  output logic                       power_inhibit_o,
  output logic                       beep_o,
  output logic      [NUM_TERM-1:0]   term_fail_o
);
  localparam int SYNC_W = 2*VID_W + 2*NUM_FAN + 2*NUM_TERM + 3;  // synchronised pins
  localparam int KCW    = 24;                                    // kick counter width
  localparam int DIVW   = 8;                                     // pwm divider width
  localparam int EVW    = NUM_FAN + NUM_TERM;                    // event bits

  // refuse parameter values the counters cannot hold
  if (KICK_CYCLES < 1 || KICK_CYCLES >= (1 << KCW)) begin : g_kick_chk
    $error("KICK_CYCLES out of range");
  end
  if (PWM_DIV < 1 || PWM_DIV > (1 << DIVW)) begin : g_div_chk
    $error("PWM_DIV out of range");
  end

  // whole state of the block
  typedef struct packed {
    logic [SYNC_W-1:0]               sync1;     // first synchroniser stage
    logic [SYNC_W-1:0]               sync2;     // second synchroniser stage
    logic [31:0]                     ctrl;      // control register
    fsmon_thr_t [NUM_AN-1:0]         sen_thr;   // sensor thresholds
    logic [NUM_AN-1:0][3:0]          sen_flag;  // registered threshold flags
    logic [NUM_FAN-1:0][7:0]         fan_crit;  // tach critical thresholds
    logic [NUM_AMB-1:0][15:0]        amb;       // {duty, temperature} pairs
    logic [7:0]                      duty_low;  // duty below the first pair
    logic [NUM_PEER-1:0]             peer;      // peer fan fault reports
    logic [NUM_FAN-1:0]              fan_en;    // enabled fan sensors
    logic [NUM_FAN-1:0]              fan_fail;  // failed fan status
    logic [NUM_TERM-1:0]             term_fail; // terminator failure status
    logic [EVW-1:0]                  evt;       // sticky events
    logic                            pwr_q;     // last power level
    logic                            hrst_q;    // last hard reset level
    logic                            fail_su;   // fan failure speed-up
    logic                            temp_su;   // over-temperature speed-up
    logic                            kick;      // power-up kick start
    logic [KCW-1:0]                  kick_cnt;  // kick cycles left
    logic [DIVW-1:0]                 div_cnt;   // pwm step divider
    logic [7:0]                      pwm_cnt;   // pwm ramp
    logic [2:0]                      level;     // ambient speed level
    logic [7:0]                      duty;      // active duty
    logic                            pwm;       // pwm pin
    logic                            fan_high;  // high speed in force
    logic                            inhibit;   // power-up blocked
    logic                            beep;      // beep request
    logic [31:0]                     rdata;     // read data
  } fsmon_st_t;

  fsmon_st_t st;          // registered state
  fsmon_st_t next;        // next state

  // synchronised pins
  logic                 hrst_s;
  logic                 pwr_s;
  logic                 ac_s;
  logic [NUM_TERM-1:0]  lvd_s;
  logic [NUM_TERM-1:0]  se_s;
  logic [NUM_FAN-1:0]   dfail_s;
  logic [NUM_FAN-1:0]   pres_s;
  logic [VID_W-1:0]     vidb_s;
  logic [VID_W-1:0]     vida_s;
  assign {hrst_s, pwr_s, ac_s, lvd_s, se_s, dfail_s, pres_s, vidb_s, vida_s} = st.sync2;

  logic [NUM_AN-1:0][3:0] an_flags;   // comparator results
  fsmon_thr_t             vid_thr;    // thresholds derived from voltage_id_bits
  logic [7:0]             vid_nom;    // nominal core reading
  logic [NUM_FAN-1:0]     avail;      // connectors usable in current mode
  logic [NUM_FAN-1:0]     pop_mask;   // populated and usable connectors
  logic [NUM_FAN-1:0]     fan_bad;    // fans failing now
  logic [NUM_TERM-1:0]    tfail_now;  // terminators failing now
  logic [7:0]             amb_rd;     // ambient reading
  logic [31:0]            rd_mux;     // read data source

  assign vid_nom     = VID_NOM_BASE - 8'({3'b000, vida_s} * VID_NOM_STEP);
  assign vid_thr.uc  = vid_nom + VID_TOL + VID_ACC;
  assign vid_thr.unc = vid_nom + VID_TOL;
  assign vid_thr.lnc = vid_nom - VID_TOL;
  assign vid_thr.lc  = vid_nom - VID_TOL - VID_ACC;

  for (genvar s = 0; s < NUM_AN; s++) begin : g_sen
    fsmon_thr_if u_if ();
    fsmon_thr_cmp u_cmp (.t(u_if));
    assign u_if.reading = an_rd_i[s*8 +: 8];
    assign u_if.thr = (s == SEN_VCORE && st.ctrl[CTRL_VRM_ONLY]) ? vid_thr : st.sen_thr[s];
    assign u_if.upper_only = st.ctrl[CTRL_TEMP_AUTO] && (s == SEN_CPU1_T || s == SEN_CPU2_T);
    assign an_flags[s] = u_if.flags;
  end

  assign amb_rd = an_rd_i[SEN_AMBIENT*8 +: 8];

  // pack mode loses the sixth connector
  assign avail    = st.ctrl[CTRL_PACK] ? NUM_FAN'((1 << NUM_PACK) - 1) : '1;
  assign pop_mask = st.ctrl[CTRL_POP_LSB +: NUM_FAN] & avail;

  // fan and terminator failure detection
  always_comb begin
    for (int i = 0; i < NUM_FAN; i++) begin
      if (!pres_s[i])
        fan_bad[i] = st.fan_en[i];
      else if (st.ctrl[CTRL_DIG_LSB + i])
        fan_bad[i] = st.fan_en[i] && dfail_s[i];
      else
        fan_bad[i] = st.fan_en[i] && (tach_rd_i[i*8 +: 8] < st.fan_crit[i]);
    end
    tfail_now = ~se_s & ~lvd_s;
  end

  // register read multiplexer
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_i == OFF_CTRL) begin
      rd_mux = st.ctrl;
    end else if (addr_i == OFF_STATUS) begin
      rd_mux = {4'h0, st.term_fail, 2'b00, st.fan_en, 5'h00, st.level,
                3'b000, st.inhibit, st.kick, st.temp_su, st.fail_su, st.fan_high};
    end else if (addr_i == OFF_EVENT) begin
      rd_mux = 32'(st.evt);
    end else if (addr_i == OFF_PEER) begin
      rd_mux = 32'(st.peer);
    end else if (addr_i == OFF_DUTY) begin
      rd_mux = {16'h0000, st.duty, st.duty_low};
    end
    for (int k = 0; k < NUM_AMB; k++) begin
      if (addr_i == AW'(int'(OFF_AMB) + 4*k))
        rd_mux = {16'h0000, st.amb[k]};
    end
    for (int i = 0; i < NUM_FAN; i++) begin
      if (addr_i == AW'(int'(OFF_FAN_CRIT) + 4*i))
        rd_mux = {24'h00_0000, st.fan_crit[i]};
      if (addr_i == AW'(int'(OFF_FAN_STAT) + 4*i))
        rd_mux = {23'h00_0000, st.fan_fail[i], tach_rd_i[i*8 +: 8]};
    end
    for (int s = 0; s < NUM_AN; s++) begin
      if (addr_i == AW'(int'(OFF_SEN_THR) + 4*s))
        rd_mux = st.sen_thr[s];
      if (addr_i == AW'(int'(OFF_SEN_STAT) + 4*s))
        rd_mux = {20'h0_0000, st.sen_flag[s], an_rd_i[s*8 +: 8]};
    end
  end

  // next state
  always_comb begin
    int lvl;
    logic [EVW-1:0] clr;
    lvl = 0;
    clr = '0;
    next = st;
    // two-stage pin synchroniser
    next.sync1 = {hard_rst_i, sys_pwr_i, ac_ok_i, term_lvd_ok_i, term_se_ok_i,
                  fan_dig_fail_i, fan_present_i, vid_b_i, vid_a_i};
    next.sync2 = st.sync1;
    next.pwr_q = pwr_s;
    next.hrst_q = hrst_s;
    next.sen_flag = an_flags;
    // register writes
    if (wr_i) begin
      if (addr_i == OFF_CTRL)
        next.ctrl = wdata_i;
      if (addr_i == OFF_EVENT)
        clr = wdata_i[EVW-1:0];
      if (addr_i == OFF_PEER)
        next.peer = wdata_i[NUM_PEER-1:0];
      if (addr_i == OFF_DUTY)
        next.duty_low = wdata_i[7:0];
      for (int k = 0; k < NUM_AMB; k++) begin
        if (addr_i == AW'(int'(OFF_AMB) + 4*k))
          next.amb[k] = wdata_i[15:0];
      end
      for (int i = 0; i < NUM_FAN; i++) begin
        if (addr_i == AW'(int'(OFF_FAN_CRIT) + 4*i))
          next.fan_crit[i] = wdata_i[7:0];
      end
      for (int s = 0; s < NUM_AN; s++) begin
        if (addr_i == AW'(int'(OFF_SEN_THR) + 4*s))
          next.sen_thr[s] = wdata_i;
      end
    end
    // enable on power-up or hard reset
    if (!pwr_s)
      next.fan_en = '0;
    else if ((pwr_s && !st.pwr_q) || (hrst_s && !st.hrst_q))
      next.fan_en = pop_mask;
    next.fan_fail = fan_bad;
    next.term_fail = tfail_now;
    next.evt = (st.evt & ~clr) | {tfail_now & ~st.term_fail, fan_bad & ~st.fan_fail};
    if (!ac_s) begin
      next.peer = '0;
      next.fail_su = 1'b0;
    end else begin
      // any fan critical or peer fault
      next.fail_su = (|fan_bad) || (|st.peer);
    end
    // over-temperature: any temperature upper non-critical
    next.temp_su = 1'b0;
    for (int t = 0; t < NUM_TEMP; t++) begin
      if (an_flags[t][2])
        next.temp_su = 1'b1;
    end
    if (!pwr_s) begin
      next.kick = 1'b0;
    end else if (!st.pwr_q) begin
      next.kick = 1'b1;
      next.kick_cnt = KCW'(KICK_CYCLES - 1);
    end else if (st.kick) begin
      if (st.kick_cnt == '0)
        next.kick = 1'b0;
      else
        next.kick_cnt = st.kick_cnt - 1'b1;
    end
    next.fan_high = st.fail_su || st.temp_su || st.kick;
    for (int k = 0; k < NUM_AMB; k++) begin
      if (amb_rd >= st.amb[k][7:0])
        lvl = lvl + 1;
    end
    next.level = 3'(lvl);
    if (st.fan_high)
      next.duty = FULL_DUTY;
    else if (st.level == 3'd0)
      next.duty = st.duty_low;
    else
      next.duty = st.amb[2'(st.level - 3'd1)][15:8];
    // pwm ramp advanced by divider enable
    if (st.div_cnt == DIVW'(PWM_DIV - 1)) begin
      next.div_cnt = '0;
      next.pwm_cnt = st.pwm_cnt + 8'h01;
    end else begin
      next.div_cnt = st.div_cnt + 1'b1;
    end
    next.pwm = (st.pwm_cnt < st.duty) || (st.duty == FULL_DUTY);
    next.inhibit = (vida_s != vidb_s);
    next.beep = (vida_s != vidb_s);
    // read data valid one cycle after strobe
    next.rdata = rd_i ? rd_mux : 32'h0000_0000;
    // synchronous reset
    if (!rst_b_i) begin
      next = '0;
      next.ctrl = CTRL_RST;
      next.sen_thr = {NUM_AN{SEN_THR_RST}};
      next.amb = {NUM_AMB{AMB_RST}};
      next.duty_low = DUTY_LOW_RST;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    st <= next;
  end

  // outputs straight from flops
  assign rdata_o         = st.rdata;
  assign pwm_o           = st.pwm;
  assign fan_high_o      = st.fan_high;
  assign power_inhibit_o = st.inhibit;
  assign beep_o          = st.beep;
  assign term_fail_o     = st.term_fail;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_pwr_rise;
    pwr_s && !st.pwr_q;
  endsequence
  sequence s_fan_bad_seen;
    ac_s && (|fan_bad);
  endsequence

  property p_upper_only;
    st.ctrl[CTRL_TEMP_AUTO] |-> (an_flags[SEN_CPU1_T][1:0] == 2'b00)
                                && (an_flags[SEN_CPU2_T][1:0] == 2'b00);
  endproperty
  a_upper_only: assert property (p_upper_only) else $error("lower flag in upper-only mode");
  property p_mismatch;
    (vida_s != vidb_s) |=> power_inhibit_o && beep_o;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("vid mismatch not acted on");
  // terminator event
  // terminators failing afresh this cycle
  logic [NUM_TERM-1:0] tnew;
  assign tnew = tfail_now & ~st.term_fail;
  property p_term_evt;
    (|tnew) |=> ((st.evt[NUM_FAN +: NUM_TERM] & term_fail_o & $past(tnew)) == $past(tnew));
  endproperty
  a_term_evt: assert property (p_term_evt) else $error("terminator event missing");
  property p_init;
    s_pwr_rise |=> (st.fan_en == $past(pop_mask));
  endproperty
  a_init: assert property (p_init) else $error("fan sensors not enabled");
  property p_fail_speedup;
    s_fan_bad_seen |=> st.fail_su ##1 fan_high_o;
  endproperty
  a_fail_speedup: assert property (p_fail_speedup) else $error("fan fault ignored");
  property p_peer;
    (ac_s && (|st.peer)) |=> st.fail_su ##1 fan_high_o;
  endproperty
  a_peer: assert property (p_peer) else $error("peer fault ignored");
  property p_or;
    (st.temp_su || st.fail_su) |=> fan_high_o ##2 pwm_o;
  endproperty
  a_or: assert property (p_or) else $error("speed-up request lost");
  property p_low;
    !(st.fail_su || st.temp_su || st.kick) |=> !fan_high_o;
  endproperty
  a_low: assert property (p_low) else $error("high speed without cause");
  property p_ac_loss;
    !ac_s |=> !st.fail_su && (st.peer == '0);
  endproperty
  a_ac_loss: assert property (p_ac_loss) else $error("fault state kept over AC loss");
  property p_kick;
    s_pwr_rise |=> st.kick ##1 fan_high_o;
  endproperty
  a_kick: assert property (p_kick) else $error("no kick start");
endmodule // fsmon_monitor

// ==== tb/fsmon_far.sv ====
// far side model: fans, analog sense points, processor id straps, terminators
`timescale 1ns/1ps
module fsmon_far
  import fsmon_pkg::*;
(
  output logic [NUM_AN*8-1:0]  an_rd_o,
  output logic [NUM_FAN*8-1:0] tach_rd_o,
  output logic [VID_W-1:0]     vid_a_o,
  output logic [VID_W-1:0]     vid_b_o,
  output logic [NUM_FAN-1:0]   fan_present_o,
  output logic [NUM_FAN-1:0]   fan_dig_fail_o,
  output logic [NUM_TERM-1:0]  term_se_ok_o,
  output logic [NUM_TERM-1:0]  term_lvd_ok_o
);
  logic [7:0]          an [NUM_AN];     // sense point levels, set by the bench
  logic [7:0]          tach [NUM_FAN];  // fan speeds while spinning
  logic [NUM_FAN-1:0]  pres;            // fan plugged in
  logic [NUM_FAN-1:0]  dfail;           // digital fan lagging
  logic [NUM_TERM-1:0] se;              // single-ended range good
  logic [NUM_TERM-1:0] lvd;             // differential range good
  logic [VID_W-1:0]    va;              // processor 1 id straps
  logic [VID_W-1:0]    vb;              // processor 2 id straps
  // quiet healthy system at time zero
  initial begin
    foreach (an[i]) an[i] = 8'h40;
    foreach (tach[i]) tach[i] = 8'h80;
    pres = '1;
    dfail = '0;
    se = '1;
    lvd = '1;
    va = '0;
    vb = '0;
  end
  // levels straight onto the pins
  always_comb begin
    for (int i = 0; i < NUM_AN; i++) an_rd_o[i*8+:8] = an[i];
    for (int i = 0; i < NUM_FAN; i++) tach_rd_o[i*8+:8] = pres[i] ? tach[i] : 8'h00;
  end
  assign fan_present_o  = pres;
  assign fan_dig_fail_o = dfail;
  assign term_se_ok_o   = se;
  assign term_lvd_ok_o  = lvd;
  assign vid_a_o        = va;
  assign vid_b_o        = vb;
endmodule // fsmon_far

// ==== tb/fan_and_sensor_monitor_tb.sv ====
// self-checking bench for the fan and sensor monitor
`timescale 1ns/1ps
module fan_and_sensor_monitor_tb;
  import fsmon_pkg::*;
  localparam int KICK = 20;  // shortened power-up high interval
  logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0;
  logic ac_ok = 1'b1, sys_pwr = 1'b0, hard_rst = 1'b0;
  logic [AW-1:0] addr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [NUM_AN*8-1:0] an_rd;
  logic [NUM_FAN*8-1:0] tach_rd;
  logic [VID_W-1:0] vid_a, vid_b;
  logic [NUM_FAN-1:0] pres, dfail;
  logic [NUM_TERM-1:0] se_ok, lvd_ok, term_fail;
  logic pwm, fan_high, inhibit, beep;
  int fail_count = 0, total_checks = 0, cyc = 0;
  logic [7:0] rv [4] = '{8'h08, 8'h74, 8'h7C, 8'h08};  // slot 2 readings
  logic [3:0] fv [4] = '{4'h3, 4'h4, 4'hC, 4'h0};      // expected flags
  wire [7:0] outs = {pwm, fan_high, inhibit, beep, term_fail};
  always #2.5 clk = ~clk;
  fsmon_far fsmon_far_inst (.an_rd_o(an_rd), .tach_rd_o(tach_rd), .vid_a_o(vid_a),
    .vid_b_o(vid_b), .fan_present_o(pres), .fan_dig_fail_o(dfail),
    .term_se_ok_o(se_ok), .term_lvd_ok_o(lvd_ok));
  fsmon_monitor #(.KICK_CYCLES(KICK), .PWM_DIV(1)) fsmon_monitor_inst (.clk_i(clk),
    .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .an_rd_i(an_rd), .tach_rd_i(tach_rd), .vid_a_i(vid_a), .vid_b_i(vid_b),
    .fan_present_i(pres), .fan_dig_fail_i(dfail), .term_se_ok_i(se_ok),
    .term_lvd_ok_i(lvd_ok), .ac_ok_i(ac_ok), .sys_pwr_i(sys_pwr), .hard_rst_i(hard_rst),
    .pwm_o(pwm), .fan_high_o(fan_high), .power_inhibit_o(inhibit), .beep_o(beep),
    .term_fail_o(term_fail));
  // counts, verdict and end of run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one write cycle, then a quiet cycle so strobes never double up
  task automatic wreg(input logic [AW-1:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    wt(1);
    wr <= 1'b0;
    wt(1);
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [AW-1:0] a, input logic [31:0] m, input logic [31:0] e);
    addr <= a;
    rd <= 1'b1;
    wt(1);
    rd <= 1'b0;
    #1 chk(rdata & m, e);
    wt(1);
  endtask
  // output pins sampled mid-cycle, away from the edge
  task automatic pins(input logic [7:0] m, input logic [7:0] e);
    @(negedge clk);
    chk({24'h0, outs & m}, {24'h0, e});
    wt(1);
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    wt(10);
    rst_b <= 1'b1;
    wt(2);
    rchk(OFF_CTRL, '1, CTRL_RST);
    rchk(OFF_SEN_THR, '1, SEN_THR_RST);
    rchk(OFF_DUTY, 32'h0000_00FF, {24'h0, DUTY_LOW_RST});
    rchk(10'h3FC, '1, '0);
    rchk(OFF_STATUS, 32'h003F_0000, '0);
    pins(8'h7F, 8'h00);
    $display("test reset done");
    wreg(OFF_CTRL, 32'h0008_3F00);
    sys_pwr <= 1'b1;
    // full duty reaches the pwm pin three cycles after the kick flag
    wt(6);
    pins(8'hC0, 8'hC0);
    rchk(OFF_STATUS, 32'h003F_0008, 32'h003F_0008);
    wt(KICK + 5);
    pins(8'h40, 8'h00);
    $display("test kick done");
    wreg(OFF_FAN_CRIT, 32'h0000_0030);
    fsmon_far_inst.tach[0] <= 8'h20;
    wt(6);
    pins(8'h40, 8'h40);
    rchk(OFF_EVENT, 32'h0000_003F, 32'h0000_0001);
    rchk(OFF_FAN_STAT, 32'h0000_01FF, 32'h0000_0120);
    rchk(OFF_STATUS, 32'h0000_0006, 32'h0000_0002);
    fsmon_far_inst.tach[0] <= 8'h80;
    wt(6);
    pins(8'h40, 8'h00);
    for (int k = 0; k < 3; k++) begin
      case (k)
        0: fsmon_far_inst.pres[2] <= 1'b0;
        1: fsmon_far_inst.dfail[3] <= 1'b1;
        default: wreg(OFF_PEER, 32'h0000_0001);
      endcase
      wt(6);
      pins(8'h40, 8'h40);
      fsmon_far_inst.pres <= '1;
      fsmon_far_inst.dfail <= '0;
      wreg(OFF_PEER, '0);
      wt(6);
      pins(8'h40, 8'h00);
    end
    wreg(OFF_EVENT, 32'h0000_03FF);
    rchk(OFF_EVENT, 32'h0000_03FF, '0);
    $display("test fan failure done");
    wreg(OFF_SEN_THR + 10'h008, 32'h1020_7078);
    for (int i = 0; i < 4; i++) begin
      wreg(OFF_CTRL, 32'h0008_3F00 | (i == 3));
      fsmon_far_inst.an[2] <= rv[i];
      wt(4);
      rchk(OFF_SEN_STAT + 10'h008, 32'h0000_0FFF, {20'h0, fv[i], rv[i]});
    end
    fsmon_far_inst.an[2] <= 8'h74;
    wt(4);
    rchk(OFF_STATUS, 32'h0000_0007, 32'h0000_0005);
    fsmon_far_inst.an[2] <= 8'h40;
    wt(4);
    pins(8'h40, 8'h00);
    $display("test thresholds done");
    wreg(OFF_AMB, 32'h0000_8030);
    wt(4);
    rchk(OFF_STATUS, 32'h0000_0701, 32'h0000_0100);
    rchk(OFF_DUTY, 32'h0000_FF00, 32'h0000_8000);
    rchk(OFF_FAN_STAT + 10'h004, 32'h0000_0100, '0);
    fsmon_far_inst.an[1] <= 8'h20;
    wt(4);
    rchk(OFF_DUTY, 32'h0000_FF00, 32'h0000_4000);
    $display("test ambient done");
    fsmon_far_inst.se[1] <= 1'b0;
    wt(6);
    pins(8'h0F, 8'h00);
    fsmon_far_inst.lvd[1] <= 1'b0;
    wt(6);
    pins(8'h0F, 8'h02);
    rchk(OFF_EVENT, 32'h0000_03C0, 32'h0000_0080);
    fsmon_far_inst.va <= 5'h01;
    wt(6);
    pins(8'h30, 8'h30);
    fsmon_far_inst.va <= 5'h00;
    wt(6);
    pins(8'h30, 8'h00);
    wreg(OFF_CTRL, 32'h0008_3F02);
    fsmon_far_inst.an[8] <= 8'hC9;
    wt(4);
    rchk(OFF_SEN_STAT + 10'h020, 32'h0000_0F00, 32'h0000_0400);
    fsmon_far_inst.an[8] <= 8'hB3;
    wt(4);
    rchk(OFF_SEN_STAT + 10'h020, 32'h0000_0F00, 32'h0000_0300);
    $display("test terminator and id done");
    fsmon_far_inst.pres[4] <= 1'b0;
    wreg(OFF_PEER, 32'h0000_0001);
    ac_ok <= 1'b0;
    wt(6);
    rchk(OFF_STATUS, 32'h0000_0003, '0);
    rchk(OFF_PEER, 32'h0000_00FF, '0);
    ac_ok <= 1'b1;
    wt(6);
    pins(8'h40, 8'h40);
    wreg(OFF_CTRL, 32'h0008_0F00);
    hard_rst <= 1'b1;
    wt(6);
    rchk(OFF_STATUS, 32'h003F_0000, 32'h000F_0000);
    // second hard reset in pack mode: the sixth connector stays off
    hard_rst <= 1'b0;
    wreg(OFF_CTRL, 32'h0008_3F04);
    hard_rst <= 1'b1;
    wt(6);
    rchk(OFF_STATUS, 32'h003F_0000, 32'h001F_0000);
    $display("test ac loss and hard reset done");
    give_verdict();
  end
endmodule // fan_and_sensor_monitor_tb
